/* File: logic/pwm_timebase_consts.svh */
// Purpose: constants for the pwm counter and match unit
// Assumes: one clock, synchronous active-low reset
// Notes:   reset values of counter state
`ifndef PWM_TIMEBASE_CONSTS_SVH
`define PWM_TIMEBASE_CONSTS_SVH
`define CNT_W         16
`define CNT_RESET     16'h0000
`define LOAD_RESET    16'h0000
`define MATCH_RESET   16'h0000
`define DIR_DOWN      1'b0
`define DIR_UP        1'b1
`endif

/* File: logic/pwm_timebase_pkg.sv */
// Purpose: types for the pwm counter and match unit
// Assumes: constants header included
// Notes:   none
`include "pwm_timebase_consts.svh"
package pwm_timebase_pkg;
   typedef logic [`CNT_W-1:0] count_t;
   typedef enum logic {
      MODE_DOWN,
      MODE_UPDOWN
   } count_mode_e;
endpackage : pwm_timebase_pkg

/* File: logic/match_compare.sv */
// Purpose: one match comparator with direction qualified pulses
// Assumes: counter and active values from the timebase
// Notes:   combinational pulses
`timescale 1ns/1ns
`include "pwm_timebase_consts.svh"
module match_compare
   import pwm_timebase_pkg::*;
(
   input  wire logic [`CNT_W-1:0] count,
   input  wire logic [`CNT_W-1:0] load_val,
   input  wire logic [`CNT_W-1:0] match_val,
   input  wire logic              dir,
   input  wire logic              running,
   output logic                   match_up,
   output logic                   match_down
);
   logic hit;
   // no pulse when match exceeds load
   assign hit        = running && (count == match_val) && (match_val <= load_val);
   assign match_up   = hit && (dir == `DIR_UP);
   assign match_down = hit && (dir == `DIR_DOWN);
endmodule : match_compare

/* File: logic/pwm_timebase.sv */
// Purpose: pwm counter and two match comparators
// Assumes: all inputs synchronous to sys_clk
// Notes:   events are one-cycle pulses of the current count
//
// Contract
// - one 16-bit counter, down or up/down, with two comparators.
// - exactly one of two modes at a time.
// - down mode: load to zero, reload, repeat.
// - up/down mode: zero up to load, then down to zero, alternating.
// - direction low in down mode, toggles in up/down mode.
// - zero pulse one cycle when counter is zero.
// - load pulse one cycle when counter equals load.
// - down mode: load pulse the cycle after zero pulse.
// - each comparator pulses one cycle on match.
// - up/down mode: matches split into up and down events.
// - match above load never pulses.
// - both outputs share this counter, same period.
// - immediate update: new values used at next zero.
// - sync update: held until global update, then at next zero.
// - global reset clears selected counter synchronously.
// - debug stall: stop at zero or keep running; no interrupt.
`timescale 1ns/1ns
`include "pwm_timebase_consts.svh"
module pwm_timebase
   import pwm_timebase_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic              enable,
   input  wire logic              mode_updown,
   input  wire logic              sync_update_mode,
   input  wire logic              global_sync,
   input  wire logic              global_reset,
   input  wire logic              debug_stall,
   input  wire logic              stall_run,
   input  wire logic [`CNT_W-1:0] load_wr,
   input  wire logic [`CNT_W-1:0] match_a_wr,
   input  wire logic [`CNT_W-1:0] match_b_wr,
   input  wire logic              values_wr,
   output logic [`CNT_W-1:0]      count,
   output logic                   dir,
   output logic                   zero_pulse,
   output logic                   load_pulse,
   output logic                   match_a_up,
   output logic                   match_a_down,
   output logic                   match_b_up,
   output logic                   match_b_down,
   output logic [`CNT_W-1:0]      load_active,
   output logic                   pending_update
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      count_t count;
      logic   dir;
      logic   running;
      logic   armed;
      logic   pend;
      count_t load_p;
      count_t ma_p;
      count_t mb_p;
      count_t load_a;
      count_t ma_a;
      count_t mb_a;
   } tb_state_s;

   tb_state_s   st_q;
   tb_state_s   st_d;

   // ************************************************************
   // mode and step
   // ************************************************************
   count_mode_e mode;
   logic        down_mode;
   logic        step;
   logic        at_zero;
   logic        freeze;

   assign mode      = mode_updown ? MODE_UPDOWN : MODE_DOWN;
   assign down_mode = (mode == MODE_DOWN);
   assign at_zero   = (st_q.count == `CNT_RESET);
   // stall without run-on freezes once zero is reached
   assign freeze    = debug_stall && !stall_run && at_zero;
   assign step      = enable && !freeze;

   // ************************************************************
   // step helpers
   // ************************************************************
   count_t count_inc;
   count_t count_dec;
   count_t turn_down_val;
   count_t turn_up_val;
   logic   counting_up;
   logic   at_top;
   logic   load_zero;

   assign count_inc     = count_t'(st_q.count + 16'h0001);
   assign count_dec     = count_t'(st_q.count - 16'h0001);
   assign load_zero     = (st_q.load_a == `CNT_RESET);
   // load of zero parks the count at zero
   assign turn_down_val = load_zero ? `CNT_RESET : count_t'(st_q.load_a - 16'h0001);
   assign turn_up_val   = load_zero ? `CNT_RESET : 16'h0001;
   assign counting_up   = (st_q.dir == `DIR_UP);
   assign at_top        = (st_q.count >= st_q.load_a);

   // ************************************************************
   // update control
   // ************************************************************
   logic take_update;
   logic arm_now;
   logic arm_on_write;

   // a write in the zero cycle waits for the next zero
   assign take_update  = step && at_zero && st_q.armed && !values_wr;
   assign arm_now      = global_sync && st_q.pend;
   assign arm_on_write = !sync_update_mode;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      st_d.count   = st_q.count;
      st_d.dir     = st_q.dir;
      st_d.running = enable;
      st_d.armed   = st_q.armed;
      st_d.pend    = st_q.pend;
      st_d.load_p  = st_q.load_p;
      st_d.ma_p    = st_q.ma_p;
      st_d.mb_p    = st_q.mb_p;
      st_d.load_a  = st_q.load_a;
      st_d.ma_a    = st_q.ma_a;
      st_d.mb_a    = st_q.mb_a;
      // capture of new values
      if (values_wr)
      begin
         st_d.load_p = load_wr;
         st_d.ma_p   = match_a_wr;
         st_d.mb_p   = match_b_wr;
         st_d.pend   = 1'b1;
         st_d.armed  = arm_on_write;
      end
      else
      begin
         if (arm_now)
         begin
            st_d.armed = 1'b1;
         end
      end
      // counter step
      if (step)
      begin
         unique case (mode)
            MODE_DOWN:
            begin
               st_d.dir = `DIR_DOWN;
               if (at_zero)
               begin
                  st_d.count = st_q.load_a;
               end
               else
               begin
                  st_d.count = count_dec;
               end
            end
            MODE_UPDOWN:
            begin
               if (counting_up)
               begin
                  if (at_top)
                  begin
                     st_d.dir   = `DIR_DOWN;
                     st_d.count = turn_down_val;
                  end
                  else
                  begin
                     st_d.count = count_inc;
                  end
               end
               else
               begin
                  if (at_zero)
                  begin
                     st_d.dir   = `DIR_UP;
                     st_d.count = turn_up_val;
                  end
                  else
                  begin
                     st_d.count = count_dec;
                  end
               end
            end
         endcase
      end
      // pending values go live at zero
      if (take_update)
      begin
         st_d.load_a = st_q.load_p;
         st_d.ma_a   = st_q.ma_p;
         st_d.mb_a   = st_q.mb_p;
         st_d.pend   = 1'b0;
         st_d.armed  = 1'b0;
         if (down_mode)
         begin
            st_d.count = st_q.load_p;
         end
      end
      // global reset wins over the count and direction updates
      if (global_reset)
      begin
         st_d.count = `CNT_RESET;
         st_d.dir   = `DIR_UP;
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         st_q         <= '0;
         st_q.count   <= `CNT_RESET;
         st_q.dir     <= `DIR_DOWN;
         st_q.running <= 1'b0;
         st_q.armed   <= 1'b0;
         st_q.pend    <= 1'b0;
         st_q.load_p  <= `LOAD_RESET;
         st_q.load_a  <= `LOAD_RESET;
         st_q.ma_p    <= `MATCH_RESET;
         st_q.mb_p    <= `MATCH_RESET;
         st_q.ma_a    <= `MATCH_RESET;
         st_q.mb_a    <= `MATCH_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ************************************************************
   // events
   // ************************************************************
   localparam int N_CMP = 2;

   logic   dir_eff;
   logic   fresh;
   logic   at_load;
   count_t cmp_val  [0:N_CMP-1];
   logic   cmp_up   [0:N_CMP-1];
   logic   cmp_down [0:N_CMP-1];

   // no pulse unless enable was high at the last clock edge
   assign fresh      = st_q.running;
   assign at_load    = (st_q.count == st_q.load_a);
   assign dir_eff    = down_mode ? `DIR_DOWN : st_q.dir;
   assign zero_pulse = fresh && at_zero;
   assign load_pulse = fresh && at_load;

   // ************************************************************
   // comparator values
   // ************************************************************
   assign cmp_val[0] = st_q.ma_a;
   assign cmp_val[1] = st_q.mb_a;

   // ************************************************************
   // comparators
   // ************************************************************
   // both comparators watch the one shared counter
   generate
      for (genvar g = 0; g < N_CMP; g++)
      begin : g_cmp
         match_compare u_cmp
         (
            .count      (st_q.count),
            .load_val   (st_q.load_a),
            .match_val  (cmp_val[g]),
            .dir        (dir_eff),
            .running    (fresh),
            .match_up   (cmp_up[g]),
            .match_down (cmp_down[g])
         );
      end
   endgenerate

   // ************************************************************
   // pulse outputs
   // ************************************************************
   assign match_a_up   = cmp_up[0];
   assign match_a_down = cmp_down[0];
   assign match_b_up   = cmp_up[1];
   assign match_b_down = cmp_down[1];

   // ************************************************************
   // value outputs
   // ************************************************************
   assign count          = st_q.count;
   assign dir            = dir_eff;
   assign load_active    = st_q.load_a;
   assign pending_update = st_q.pend;
endmodule : pwm_timebase

/* File: verification/pwm_timebase_props.sv */
// Purpose: assertions on pwm_timebase ports
// Assumes: one clock, sync reset
// Notes: bound after endmodule
`timescale 1ns/1ns
module pwm_timebase_props
   import pwm_timebase_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        enable,
   input wire logic        mode_updown,
   input wire logic        global_reset,
   input wire logic        debug_stall,
   input wire logic        stall_run,
   input wire logic [15:0] count,
   input wire logic [15:0] load_active,
   input wire logic        dir,
   input wire logic        load_pulse,
   input wire logic        zero_pulse,
   input wire logic        match_a_up,
   input wire logic        match_a_down,
   input wire logic        match_b_up
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   wire run_ok = enable && !global_reset;
   property p_down; run_ok && !mode_updown && count != 0 |=> count == $past(count) - 1; endproperty
   property p_up; run_ok && mode_updown && dir && count != 0 && count < load_active
      |=> count == $past(count) + 1; endproperty
   property p_hold; !enable && !global_reset |=> $stable(count); endproperty
   property p_dir; !mode_updown && !global_reset ##1 !mode_updown |-> !dir; endproperty
   property p_reload; zero_pulse && !mode_updown && run_ok && !debug_stall |=> load_pulse;
   endproperty
   property p_load; load_pulse |-> count == load_active; endproperty
   property p_cap; match_a_up || match_a_down |-> count <= load_active; endproperty
   property p_qual; match_b_up |-> dir; endproperty
   property p_greset; global_reset |=> count == 16'h0000; endproperty
   property p_stall; debug_stall && !stall_run && count == 0 |=> count == 16'h0000; endproperty
   a_down: assert property (p_down) else $error("down step wrong");
   a_up: assert property (p_up) else $error("up step wrong");
   a_hold: assert property (p_hold) else $error("count moved while off");
   a_dir: assert property (p_dir) else $error("dir high in down mode");
   a_reload: assert property (p_reload) else $error("no load after zero");
   a_load: assert property (p_load) else $error("load pulse off value");
   a_cap: assert property (p_cap) else $error("match above load");
   a_qual: assert property (p_qual) else $error("up match without dir");
   a_greset: assert property (p_greset) else $error("global reset ignored");
   a_stall: assert property (p_stall) else $error("stall left zero");
   c_zero: cover property (zero_pulse);
   c_adown: cover property (match_a_down);
   c_bup: cover property (match_b_up);
endmodule : pwm_timebase_props
bind pwm_timebase pwm_timebase_props pwm_timebase_props_i (.*);

/* File: verification/pwm_event_sink.sv */
// Purpose: downstream pwm generator model
// Assumes: pulses from pwm_timebase
// Notes: counts zero events, drives pwm a
`timescale 1ns/1ns
module pwm_event_sink
   import pwm_timebase_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        zero_pulse,
   input  wire logic        match_a_up,
   input  wire logic        match_a_down,
   output logic [15:0]      zero_seen,
   output logic             pwm_a
);
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         zero_seen <= 16'h0000;
         pwm_a <= 1'b0;
      end
      else
      begin
         zero_seen <= zero_seen + zero_pulse;
         if (match_a_up) pwm_a <= 1'b1;
         else if (match_a_down) pwm_a <= 1'b0;
      end
   end
endmodule : pwm_event_sink

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for pwm_timebase
// Assumes: 25 MHz clock
// Notes: reference counter in bench
`timescale 1ns/1ns
module tb_top
   import pwm_timebase_pkg::*;
;
   logic sys_clk, resetn, enable, mode_updown, sync_update_mode, global_sync, global_reset;
   logic debug_stall, stall_run, values_wr, dir, zero_pulse, load_pulse, pending_update, pwm_a;
   logic match_a_up, match_a_down, match_b_up, match_b_down;
   logic [15:0] load_wr, match_a_wr, match_b_wr, count, load_active, zero_seen;
   integer seed = 32'heec7, fails = 0, checks = 0, i, n, rc, rl, ra, rb, zc;
   bit rup, ud;
   pwm_timebase pwm_timebase_i (.*);
   pwm_event_sink pwm_event_sink_i (.*);
   initial
   begin
      sys_clk = 0;
      forever #20 sys_clk = ~sys_clk;
   end
   task tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   task cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task tick;
      @(posedge sys_clk);
      #1;
   endtask : tick
   task wr(input integer l, input integer a, input integer b);
      load_wr = l[15:0];
      match_a_wr = a[15:0];
      match_b_wr = b[15:0];
      values_wr = 1;
      tick;
      values_wr = 0;
      for (n = 0; pending_update !== 1'b0 && n < 300; n++) tick;
   endtask : wr
   task sync0;
      global_reset = 1;
      tick;
      global_reset = 0;
      rc = 0;
      rup = 1;
   endtask : sync0
   task run(input integer cyc);
      for (n = 0; n < cyc; n++)
      begin
         cmp(count, rc[15:0]);
         cmp(dir, ud && rup);
         cmp(zero_pulse, rc == 0);
         cmp(load_pulse, rc == rl);
         cmp(match_a_up, ud && rup && rc == ra);
         cmp(match_a_down, (!ud || !rup) && rc == ra);
         cmp(match_b_up, ud && rup && rc == rb);
         cmp(match_b_down, (!ud || !rup) && rc == rb);
         zc = zc + (rc == 0);
         tick;
         if (!ud) rup = 0;
         else if (rup && rc >= rl) rup = 0;
         else if (!rup && rc == 0) rup = 1;
         if (!ud) rc = rc == 0 ? rl : rc - 1;
         else rc = rup ? rc + 1 : rc - 1;
      end
   endtask : run
   initial
   begin
      #2000000;
      fails++;
      tally_and_finish;
   end
   initial
   begin
      {enable, mode_updown, sync_update_mode, global_sync, global_reset} = 0;
      {debug_stall, stall_run, values_wr, resetn} = 0;
      {load_wr, match_a_wr, match_b_wr} = 0;
      repeat (8) tick;
      resetn = 1;
      enable = 1;
      for (i = 0; i < 6; i++)
      begin
         ud = i[0];
         mode_updown = ud;
         rl = 2 + {$random(seed)} % 40;
         ra = ud ? 1 + {$random(seed)} % (rl - 1) : {$random(seed)} % (rl + 3);
         rb = i == 0 ? rl + 1 : ud ? 1 + {$random(seed)} % (rl - 1) : {$random(seed)} % rl;
         wr(rl, ra, rb);
         cmp(load_active, rl[15:0]);
         sync0;
         zc = zero_seen;
         run(3 * rl + 4);
         cmp(zero_seen, zc[15:0]);
      end
      sync_update_mode = 1;
      load_wr = rl[15:0] + 2;
      values_wr = 1;
      tick;
      values_wr = 0;
      sync0;
      run(2 * rl + 4);
      cmp(pending_update, 16'h0001);
      global_sync = 1;
      wr(rl + 2, ra, rb);
      global_sync = 0;
      cmp(load_active, rl[15:0] + 2);
      debug_stall = 1;
      repeat (2 * rl + 12) tick;
      cmp(count, 16'h0000);
      debug_stall = 0;
      sync0;
      repeat (3) tick;
      enable = 0;
      repeat (5) tick;
      cmp(count, 16'h0003);
      tally_and_finish;
   end
endmodule : tb_top
